// ### logic/ivr_pkg.sv
// What this block does
// - A smaller vector number wins over any larger pending vector number.
// - A vector is a byte pair: routine high byte first, low byte next.
// - A source event sets its flag whatever its local enable holds.
// - A set flag requests service only while its local enable is 1.
// - After stacking and masking the core fetches; smallest pending vector number is presented.
// - Vector 39 comes from command complete or either fault flag, one enable.
// - Vectors 38, 36, 34, 33 to 26, 20 and 19 are never requested.
// - Vector 37 comes from the keypad flag under the keypad enable.
// - Vector 35 comes from the periodic overflow flag under its enable.
// - Vector 25 comes from transmit empty or transmission complete, each enabled.
// - Vector 24 comes from idle, receive full, break or receive edge, each enabled.
// - Vector 23 comes from overrun, noise, framing or parity, each enabled.
// - Vector 22 comes from conversion complete under the converter enable.
// - Vector 21 comes from the comparator flag under the comparator enable.
// - Vector 18 comes from the first timer overflow flag under its enable.
// - Vector 17 comes from the first timer channel one flag under its enable.
// - Vector 16 comes from the first timer channel zero flag under its enable.
// - Vector 15 comes from the second timer overflow flag under its enable.
// - Vector 14 comes from the second timer channel one flag under its enable.
package ivr_pkg;

	// ****************************************************************
	// Flag positions
	// ****************************************************************
	localparam int NUM_FLAGS                = 22;
	localparam int FLAG_COMMAND_COMPLETE    = 0;
	localparam int FLAG_DOUBLE_FAULT        = 1;
	localparam int FLAG_SINGLE_FAULT        = 2;
	localparam int FLAG_KEYPAD_EVENT        = 3;
	localparam int FLAG_PERIODIC_OVERFLOW   = 4;
	localparam int FLAG_TRANSMIT_EMPTY      = 5;
	localparam int FLAG_TRANSMIT_COMPLETE   = 6;
	localparam int FLAG_IDLE_LINE           = 7;
	localparam int FLAG_RECEIVE_FULL        = 8;
	localparam int FLAG_BREAK_DETECT        = 9;
	localparam int FLAG_RECEIVE_EDGE        = 10;
	localparam int FLAG_OVERRUN_ERROR       = 11;
	localparam int FLAG_NOISE_ERROR         = 12;
	localparam int FLAG_FRAMING_ERROR       = 13;
	localparam int FLAG_PARITY_ERROR        = 14;
	localparam int FLAG_CONVERSION_COMPLETE = 15;
	localparam int FLAG_COMPARATOR_EVENT    = 16;
	localparam int FLAG_T0_OVERFLOW         = 17;
	localparam int FLAG_T0_CHANNEL_ONE      = 18;
	localparam int FLAG_T0_CHANNEL_ZERO     = 19;
	localparam int FLAG_T1_OVERFLOW         = 20;
	localparam int FLAG_T1_CHANNEL_ONE      = 21;

	// ****************************************************************
	// Vector numbering
	// ****************************************************************
	localparam int VEC_LOWEST               = 14;
	localparam int VEC_HIGHEST              = 39;
	localparam int VEC_NVM                  = 39;
	localparam int VEC_KEYPAD               = 37;
	localparam int VEC_PERIODIC             = 35;
	localparam int VEC_SERIAL_TRANSMIT      = 25;
	localparam int VEC_SERIAL_RECEIVE       = 24;
	localparam int VEC_SERIAL_ERROR         = 23;
	localparam int VEC_CONVERTER            = 22;
	localparam int VEC_COMPARATOR           = 21;
	localparam int VEC_T0_OVERFLOW          = 18;
	localparam int VEC_T0_CHANNEL_ONE       = 17;
	localparam int VEC_T0_CHANNEL_ZERO      = 16;
	localparam int VEC_T1_OVERFLOW          = 15;
	localparam int VEC_T1_CHANNEL_ONE       = 14;
	localparam logic [15:0] VEC_TOP_ADDR    = 16'hfffe;

	// ****************************************************************
	// Register map, byte addresses
	// ****************************************************************
	localparam logic [4:0] OFS_FLAG         = 5'h00;
	localparam logic [4:0] OFS_ENABLE       = 5'h04;
	localparam logic [4:0] OFS_PENDING      = 5'h08;
	localparam logic [4:0] OFS_CURRENT      = 5'h0c;
	localparam logic [4:0] OFS_FETCHED      = 5'h10;
	localparam logic [21:0] ENABLE_RESET    = 22'h000000;
	localparam logic [21:0] ENABLE_WRITABLE = 22'h3ffff9;
	localparam logic [21:0] FLAG_RESET      = 22'h000000;

	typedef struct packed {
		logic        found;
		logic [5:0]  number;
		logic [15:0] addr_high;
		logic [15:0] addr_low;
	} ivr_vector_t;

endpackage : ivr_pkg

// ### logic/ivr_top.sv
`timescale 1ns/1ps
module ivr_top (
	input  wire logic                     clk_sys,
	input  wire logic                     rst_n,
	input  wire logic [4:0]               avs_address,
	input  wire logic                     avs_read,
	input  wire logic                     avs_write,
	input  wire logic [31:0]              avs_writedata,
	input  wire logic [3:0]               avs_byteenable,
	output logic      [31:0]              avs_readdata,
	output logic                          avs_waitrequest,
	input  wire logic [21:0]              src_set,
	input  wire logic [21:0]              src_clear,
	input  wire logic                     core_vector_fetch,
	output logic                          core_irq_request,
	output logic                          core_vector_valid,
	output ivr_pkg::ivr_vector_t          core_vector
);

	// ****************************************************************
	// Flags and enables
	// ****************************************************************
	logic [21:0]              flag;
	logic [21:0]              enable;
	logic [21:0]              eff_enable;
	logic [21:0]              gated;
	logic [39:0]              vec_req;
	ivr_pkg::ivr_vector_t     next_vector;
	logic [31:0]              next_readdata;
	logic                     bus_req;
	logic                     bus_done;
	logic [21:0]              lane_mask;

	// The clear from the peripheral loses to a fresh event in the same cycle.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			flag <= ivr_pkg::FLAG_RESET;
		end else begin
			flag <= (flag & ~src_clear) | src_set;
		end
	end

	assign bus_req  = avs_read | avs_write;
	assign bus_done = bus_req & ~avs_waitrequest;

	// The top lane holds only six enable bits, so lane 3 has nothing to write.
	assign lane_mask = {{6{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

	// Bits of the two fault flags have no enable of their own and read as zero.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			enable <= ivr_pkg::ENABLE_RESET;
		end else if (bus_done && avs_write && avs_address == ivr_pkg::OFS_ENABLE) begin
			enable <= (enable & ~lane_mask)
				| (avs_writedata[21:0] & lane_mask & ivr_pkg::ENABLE_WRITABLE);
		end
	end

	// ****************************************************************
	// Gating and vector requests
	// ****************************************************************
	always_comb begin
		eff_enable = enable;
		eff_enable[ivr_pkg::FLAG_DOUBLE_FAULT] = enable[ivr_pkg::FLAG_COMMAND_COMPLETE];
		eff_enable[ivr_pkg::FLAG_SINGLE_FAULT] = enable[ivr_pkg::FLAG_COMMAND_COMPLETE];
	end

	assign gated = flag & eff_enable;

	// Unused vector numbers are never assigned and stay zero.
	always_comb begin
		vec_req = 40'h0000000000;
		vec_req[ivr_pkg::VEC_NVM] = |gated[2:0];
		vec_req[ivr_pkg::VEC_KEYPAD] = gated[ivr_pkg::FLAG_KEYPAD_EVENT];
		vec_req[ivr_pkg::VEC_PERIODIC] = gated[ivr_pkg::FLAG_PERIODIC_OVERFLOW];
		vec_req[ivr_pkg::VEC_SERIAL_TRANSMIT] = |gated[6:5];
		vec_req[ivr_pkg::VEC_SERIAL_RECEIVE] = |gated[10:7];
		vec_req[ivr_pkg::VEC_SERIAL_ERROR] = |gated[14:11];
		vec_req[ivr_pkg::VEC_CONVERTER] = gated[ivr_pkg::FLAG_CONVERSION_COMPLETE];
		vec_req[ivr_pkg::VEC_COMPARATOR] = gated[ivr_pkg::FLAG_COMPARATOR_EVENT];
		vec_req[ivr_pkg::VEC_T0_OVERFLOW] = gated[ivr_pkg::FLAG_T0_OVERFLOW];
		vec_req[ivr_pkg::VEC_T0_CHANNEL_ONE] = gated[ivr_pkg::FLAG_T0_CHANNEL_ONE];
		vec_req[ivr_pkg::VEC_T0_CHANNEL_ZERO] = gated[ivr_pkg::FLAG_T0_CHANNEL_ZERO];
		vec_req[ivr_pkg::VEC_T1_OVERFLOW] = gated[ivr_pkg::FLAG_T1_OVERFLOW];
		vec_req[ivr_pkg::VEC_T1_CHANNEL_ONE] = gated[ivr_pkg::FLAG_T1_CHANNEL_ONE];
	end

	// Scanning downward lets the smallest pending number be the last one kept.
	always_comb begin
		logic [15:0] base;
		base = ivr_pkg::VEC_TOP_ADDR;
		next_vector = '0;
		for (int v = ivr_pkg::VEC_HIGHEST; v >= ivr_pkg::VEC_LOWEST; v--) begin
			if (vec_req[v]) begin
				next_vector.found  = 1'b1;
				next_vector.number = 6'(v);
			end
		end
		if (next_vector.found) begin
			base = ivr_pkg::VEC_TOP_ADDR - {9'h000, next_vector.number, 1'b0};
		end
		next_vector.addr_high = base;
		next_vector.addr_low  = base + 16'h0001;
	end

	// ****************************************************************
	// Processor side
	// ****************************************************************
	// The core masks further entries itself; this side only answers each fetch.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			core_irq_request <= 1'b0;
		end else begin
			core_irq_request <= next_vector.found;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			core_vector_valid <= 1'b0;
			core_vector       <= '0;
		end else begin
			core_vector_valid <= core_vector_fetch;
			if (core_vector_fetch) begin
				core_vector <= next_vector;
			end
		end
	end

	// ****************************************************************
	// Register bus
	// ****************************************************************
	always_comb begin
		next_readdata = 32'h00000000;
		case (avs_address)
			ivr_pkg::OFS_FLAG:    next_readdata = {10'h000, flag};
			ivr_pkg::OFS_ENABLE:  next_readdata = {10'h000, enable};
			ivr_pkg::OFS_PENDING: next_readdata = {10'h000, gated};
			ivr_pkg::OFS_CURRENT: next_readdata = {next_vector.addr_high, 8'h00,
				next_vector.found, 1'b0, next_vector.number};
			ivr_pkg::OFS_FETCHED: next_readdata = {core_vector.addr_high, 8'h00,
				core_vector.found, 1'b0, core_vector.number};
			default:              next_readdata = 32'h00000000;
		endcase
	end

	// One wait cycle per access keeps read data a registered value.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h00000000;
		end else begin
			avs_waitrequest <= ~(bus_req & avs_waitrequest);
			if (bus_req && avs_waitrequest) begin
				avs_readdata <= avs_read ? next_readdata : 32'h00000000;
			end
		end
	end

endmodule : ivr_top

// ### dv/ivr_core_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Core side: takes a request, stacks, masks, then fetches once.
// ****************************************************************
module ivr_core_model (
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic core_irq_request,
	output logic      core_vector_fetch
);
	logic [2:0] step;
	logic       masked;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			step <= 3'h0;
			core_vector_fetch <= 1'b0;
		end else begin
			core_vector_fetch <= (step == 3'h6);
			if (step != 3'h0)
				step <= step + 3'h1;
			else if (core_irq_request && !masked)
				step <= 3'h1;
		end
	end

	// The mask stays set until the service routine has cleared every enabled pending flag.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			masked <= 1'b1;
		else if (step == 3'h6)
			masked <= 1'b1;
		else if (step == 3'h0 && !core_irq_request)
			masked <= 1'b0;
	end
endmodule : ivr_core_model

// ### dv/ivr_top_sva.sv
`timescale 1ns/1ps
// ****************************************************************
// Port checker.
// ****************************************************************
module ivr_top_sva (
	input wire logic                 clk_sys,
	input wire logic                 rst_n,
	input wire logic                 avs_read,
	input wire logic                 avs_write,
	input wire logic                 avs_waitrequest,
	input wire logic [21:0]          src_clear,
	input wire logic                 core_vector_fetch,
	input wire logic                 core_irq_request,
	input wire logic                 core_vector_valid,
	input wire ivr_pkg::ivr_vector_t core_vector
);
	default clocking dc @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_fetch_answered: assert property (
		core_vector_fetch |=> core_vector_valid) else $error("No answer to fetch.");
	a_valid_from_fetch: assert property (
		core_vector_valid |-> $past(core_vector_fetch)) else $error("Stray valid.");
	a_pair_bytes: assert property (
		core_vector_valid |-> core_vector.addr_low == core_vector.addr_high + 16'h0001)
		else $error("Byte pair broken.");
	a_vector_address: assert property (
		core_vector_valid && core_vector.found |->
		core_vector.addr_high == 16'hfffe - {9'h000, core_vector.number, 1'b0})
		else $error("Bad vector address.");
	a_used_numbers: assert property (
		core_vector_valid && core_vector.found |-> core_vector.number inside
		{6'h27, 6'h25, 6'h23, [6'h15:6'h19], [6'h0e:6'h12]}) else $error("Unused vector.");
	a_wait_one: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("Slow bus answer.");
	a_wait_release: assert property (
		!avs_waitrequest |=> avs_waitrequest) else $error("Long answer.");
	a_request_holds: assert property (
		core_irq_request && !(|src_clear) && !(|$past(src_clear)) && !avs_write
		&& !$past(avs_write) |=> core_irq_request) else $error("Request lost.");
endmodule : ivr_top_sva

bind ivr_top ivr_top_sva ivr_top_sva_inst (.clk_sys, .rst_n, .avs_read, .avs_write,
	.avs_waitrequest, .src_clear, .core_vector_fetch, .core_irq_request,
	.core_vector_valid, .core_vector);

// ### dv/ivr_top_tb.sv
`timescale 1ns/1ps
module ivr_top_tb;
	logic                 clk_sys = 1'b0;
	logic                 rst_n = 1'b1;
	logic [4:0]           avs_address = 5'h00;
	logic                 avs_read = 1'b0;
	logic                 avs_write = 1'b0;
	logic [31:0]          avs_writedata = 32'h0;
	logic [31:0]          avs_readdata, q;
	logic                 avs_waitrequest, core_vector_fetch, core_irq_request, core_vector_valid;
	logic [21:0]          src_set = 22'h0;
	logic [21:0]          src_clear = 22'h0;
	ivr_pkg::ivr_vector_t core_vector;
	int                   error_cnt = 0;
	int                   tests_run = 0;
	int vnum [22] = '{39, 39, 39, 37, 35, 25, 25, 24, 24, 24, 24,
		23, 23, 23, 23, 22, 21, 18, 17, 16, 15, 14};
	always #4 clk_sys = ~clk_sys;
	ivr_top ivr_top_inst (.clk_sys, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .src_set, .src_clear,
		.core_vector_fetch, .core_irq_request, .core_vector_valid, .core_vector);
	ivr_core_model ivr_core_model_inst (.clk_sys, .rst_n, .core_irq_request, .core_vector_fetch);
	task automatic access(input logic wr, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		{avs_address, avs_writedata, avs_write, avs_read} <= {a, d, wr, ~wr};
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		{avs_write, avs_read} <= 2'b00;
	endtask : access
	task automatic src(input logic [21:0] s, input logic [21:0] c);
		@(posedge clk_sys);
		{src_set, src_clear} <= {s, c};
		@(posedge clk_sys);
		{src_set, src_clear} <= 44'h0;
	endtask : src
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic chkv(input ivr_pkg::ivr_vector_t got, input ivr_pkg::ivr_vector_t exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chkv
	task automatic end_of_test();
		if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (20000) @(posedge clk_sys);
		error_cnt++;
		end_of_test();
	end
	initial begin
		rst_n = 1'b0;
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		access(1'b0, ivr_pkg::OFS_ENABLE, 32'h0);
		chk(q, 32'h0);
		access(1'b0, 5'h14, 32'h0);
		chk(q, 32'h0);
		src(22'h3fffff, 22'h0);
		access(1'b1, ivr_pkg::OFS_FLAG, 32'h0);
		access(1'b0, ivr_pkg::OFS_FLAG, 32'h0);
		chk(q, 32'h3fffff);
		chk({31'h0, core_irq_request}, 32'h0);
		src(22'h0, 22'h3fffff);
		// Each source alone, enable raised before the event so no fetch is missed.
		for (int i = 0; i < 22; i++) begin
			access(1'b1, ivr_pkg::OFS_ENABLE, 32'h1 << (i < 3 ? 0 : i));
			src(22'h1 << i, 22'h0);
			do @(posedge clk_sys); while (core_vector_valid !== 1'b1);
			chkv(core_vector, {1'b1, 6'(vnum[i]), 16'(16'hfffe - 2 * vnum[i]),
				16'(16'hffff - 2 * vnum[i])});
			src(22'h0, 22'h1 << i);
		end
		access(1'b1, ivr_pkg::OFS_ENABLE, 32'h3ffff9);
		src(22'h3fffff, 22'h0);
		for (int j = 21; j >= 0; j--) begin
			access(1'b0, ivr_pkg::OFS_CURRENT, 32'h0);
			chk(q, {16'(16'hfffe - 2 * vnum[j]), 10'h002, 6'(vnum[j])});
			src(22'h0, 22'h1 << j);
		end
		access(1'b0, ivr_pkg::OFS_CURRENT, 32'h0);
		chk(q, 32'hfffe0000);
		src(22'h8, 22'h8);
		access(1'b0, ivr_pkg::OFS_FLAG, 32'h0);
		chk(q, 32'h8);
		do @(posedge clk_sys); while (core_vector_valid !== 1'b1);
		chk({31'h0, core_irq_request}, 32'h1);
		access(1'b0, ivr_pkg::OFS_PENDING, 32'h0);
		chk(q, 32'h8);
		access(1'b0, ivr_pkg::OFS_FETCHED, 32'h0);
		chk(q, 32'hffb400a5);
		end_of_test();
	end
endmodule : ivr_top_tb
